/* File: shared/ovc_pkg.sv */
// Package for the supply-line control block: register offsets, field positions, reset values.
// Assumes a byte-wide register port with six address bits, as on a ULPI register array.
package ovc_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [5:0] OVC_OTG_CTRL_ADDR   = 6'h0a;
   localparam logic [5:0] OVC_IFC_CTRL_ADDR   = 6'h07;
   localparam logic [5:0] OVC_PWR_MGMT_ADDR   = 6'h39;
   localparam logic [5:0] OVC_FUNC_CTRL_ADDR  = 6'h04;
   localparam logic [5:0] OVC_STATUS_ADDR     = 6'h13;
   localparam logic [5:0] OVC_CHG_CTRL_ADDR   = 6'h31;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int OVC_DRV_INT_BIT     = 5;
   localparam int OVC_DRV_EXT_BIT     = 6;
   localparam int OVC_DISCHARGE_BIT   = 3;
   localparam int OVC_PULLUP_BIT      = 4;
   localparam int OVC_EXT_SEL_BIT     = 7;
   localparam int OVC_INVERT_BIT      = 5;
   localparam int OVC_DIRECT_BIT      = 6;
   localparam int OVC_UART_LVL_LSB    = 0;
   localparam int OVC_OP_MODE_LSB     = 3;
   localparam int OVC_CHG_EN_BIT      = 0;
   localparam int OVC_ST_SUPPLY_BIT   = 1;
   localparam int OVC_ST_SESSION_BIT  = 2;
   localparam int OVC_ST_LINE_LSB     = 4;
   localparam int OVC_ST_UART_BIT     = 6;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [7:0] OVC_OTG_CTRL_RST   = 8'h00;
   localparam logic [7:0] OVC_IFC_CTRL_RST   = 8'h00;
   localparam logic [7:0] OVC_PWR_MGMT_RST   = 8'h00;
   localparam logic [7:0] OVC_FUNC_CTRL_RST  = 8'h00;
   localparam logic [7:0] OVC_CHG_CTRL_RST   = 8'h00;
   localparam logic [1:0] OVC_OP_MODE_UART   = 2'h2;

   typedef enum logic [1:0] {
      OVC_MODE_SYNC  = 2'b00,
      OVC_MODE_ENTER = 2'b01,
      OVC_MODE_UART  = 2'b10
   } ovc_mode_t;

endpackage

/* File: hw/ovc_sync2.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes inputs are quasi-static levels; no edges are detected here.
`timescale 1ns/1ps

module ovc_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // Levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_dout;

   // Shift chain next values
   always_comb begin
      next_stage1 = din;
      next_dout   = stage1;
   end

   // Shift chain registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end

endmodule

/* File: hw/ovc_top.sv */
// Supply-line on-the-go control: pulsing resistors, supply switch, indicator select, UART entry.
// Assumes a same-clock register master; comparator and indicator inputs are asynchronous levels.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module ovc_top (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [5:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Analog and pin inputs
   input  wire logic       comparator_supply_valid,
   input  wire logic       session_valid_flag,
   input  wire logic [1:0] line_state_raw,
   input  wire logic       external_indicator_pin,
   // Analog controls
   output logic            supply_discharge_enable,
   output logic            supply_pullup_enable,
   output logic            indicator_pulldown_enable,
   output logic      [1:0] regulator_level,
   output logic            charger_detect_enable,
   // Open-drain switch pin
   output logic            supply_switch_enable_n_out,
   output logic            supply_switch_enable_n_oe,
   // Toward the RX command path
   output logic            supply_valid_flag,
   output logic            session_valid_out,
   output logic      [1:0] line_state_out,
   output logic            uart_active
);
   import ovc_pkg::*;

   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [4:0] pins_sync;
   logic       comp_s;
   logic       sess_s;
   logic [1:0] line_s;
   logic       ext_s;

   ovc_sync2 #(
      .WIDTH (5)
   ) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .din   ({external_indicator_pin, line_state_raw, session_valid_flag, comparator_supply_valid}),
      .dout  (pins_sync)
   );

   // Split synchronised inputs
   assign comp_s = pins_sync[0];
   assign sess_s = pins_sync[1];
   assign line_s = pins_sync[3:2];
   assign ext_s  = pins_sync[4];

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] otg_ctrl;
   logic [7:0] ifc_ctrl;
   logic [7:0] pwr_mgmt;
   logic [7:0] func_ctrl;
   logic [7:0] chg_ctrl;
   logic [7:0] next_otg_ctrl;
   logic [7:0] next_ifc_ctrl;
   logic [7:0] next_pwr_mgmt;
   logic [7:0] next_func_ctrl;
   logic [7:0] next_chg_ctrl;
   logic [7:0] next_reg_rdata;
   logic [7:0] status_word;

   // Status word shows synchronised block state
   always_comb begin
      status_word = 8'h00;
      status_word[OVC_ST_SUPPLY_BIT]            = supply_valid_flag;
      status_word[OVC_ST_SESSION_BIT]           = sess_s;
      status_word[OVC_ST_LINE_LSB +: 2]         = line_state_out;
      status_word[OVC_ST_UART_BIT]              = uart_active;
   end

   // Register writes and read mux
   always_comb begin
      next_otg_ctrl  = otg_ctrl;
      next_ifc_ctrl  = ifc_ctrl;
      next_pwr_mgmt  = pwr_mgmt;
      next_func_ctrl = func_ctrl;
      next_chg_ctrl  = chg_ctrl;
      next_reg_rdata = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            OVC_OTG_CTRL_ADDR:  next_otg_ctrl  = reg_wdata;
            OVC_IFC_CTRL_ADDR:  next_ifc_ctrl  = reg_wdata;
            OVC_PWR_MGMT_ADDR:  next_pwr_mgmt  = reg_wdata;
            OVC_FUNC_CTRL_ADDR: next_func_ctrl = reg_wdata;
            OVC_CHG_CTRL_ADDR:  next_chg_ctrl  = reg_wdata;
            default:            next_otg_ctrl  = otg_ctrl;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OVC_OTG_CTRL_ADDR:  next_reg_rdata = otg_ctrl;
            OVC_IFC_CTRL_ADDR:  next_reg_rdata = ifc_ctrl;
            OVC_PWR_MGMT_ADDR:  next_reg_rdata = pwr_mgmt;
            OVC_FUNC_CTRL_ADDR: next_reg_rdata = func_ctrl;
            OVC_CHG_CTRL_ADDR:  next_reg_rdata = chg_ctrl;
            OVC_STATUS_ADDR:    next_reg_rdata = status_word;
            default:            next_reg_rdata = 8'h00;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         otg_ctrl  <= OVC_OTG_CTRL_RST;
         ifc_ctrl  <= OVC_IFC_CTRL_RST;
         pwr_mgmt  <= OVC_PWR_MGMT_RST;
         func_ctrl <= OVC_FUNC_CTRL_RST;
         chg_ctrl  <= OVC_CHG_CTRL_RST;
         reg_rdata <= 8'h00;
      end else begin
         otg_ctrl  <= next_otg_ctrl;
         ifc_ctrl  <= next_ifc_ctrl;
         pwr_mgmt  <= next_pwr_mgmt;
         func_ctrl <= next_func_ctrl;
         chg_ctrl  <= next_chg_ctrl;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ****************************************
   // Mode tracking for UART entry
   // ****************************************
   ovc_mode_t  mode;
   ovc_mode_t  next_mode;
   logic       uart_req;

   assign uart_req = (func_ctrl[OVC_OP_MODE_LSB +: 2] == OVC_OP_MODE_UART);

   // Mode sequencing
   always_comb begin
      next_mode = mode;
      case (mode)
         OVC_MODE_SYNC:  if (uart_req) begin
            next_mode = OVC_MODE_ENTER;
         end
         OVC_MODE_ENTER: next_mode = uart_req ? OVC_MODE_UART : OVC_MODE_SYNC;
         OVC_MODE_UART:  if (!uart_req) begin
            next_mode = OVC_MODE_SYNC;
         end
         default:        next_mode = OVC_MODE_SYNC;
      endcase
   end

   // Mode register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode <= OVC_MODE_SYNC;
      end else begin
         mode <= next_mode;
      end
   end

   // ****************************************
   // Output logic
   // ****************************************
   logic       drive_any;
   logic       next_supply_valid;
   logic       next_switch_oe;
   logic [1:0] next_reg_level;
   logic       next_uart_active;
   logic [1:0] next_line_state;
   logic       fault_active;

   // Output next values
   always_comb begin
      // either drive bit enables switch (OR)
      drive_any      = otg_ctrl[OVC_DRV_INT_BIT] | otg_ctrl[OVC_DRV_EXT_BIT];
      next_switch_oe = drive_any;
      fault_active   = ext_s ^ ifc_ctrl[OVC_INVERT_BIT];
      if (!otg_ctrl[OVC_EXT_SEL_BIT]) begin
         next_supply_valid = comp_s;
      end else if (ifc_ctrl[OVC_DIRECT_BIT]) begin
         next_supply_valid = fault_active;
      end else begin
         next_supply_valid = comp_s & ~fault_active;
      end
      next_uart_active = (next_mode == OVC_MODE_UART);
      // regulator level follows UART field in UART mode
      next_reg_level   = next_uart_active ? pwr_mgmt[OVC_UART_LVL_LSB +: 2] : 2'h0;
      // line state suppressed in UART mode
      next_line_state  = next_uart_active ? 2'h0 : line_s;
   end

   // Output registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         supply_discharge_enable    <= 1'b0;
         supply_pullup_enable       <= 1'b0;
         indicator_pulldown_enable  <= 1'b1;
         regulator_level            <= 2'h0;
         charger_detect_enable      <= 1'b0;
         supply_switch_enable_n_out <= 1'b0;
         supply_switch_enable_n_oe  <= 1'b0;
         supply_valid_flag          <= 1'b0;
         session_valid_out          <= 1'b0;
         line_state_out             <= 2'h0;
         uart_active                <= 1'b0;
      end else begin
         supply_discharge_enable    <= otg_ctrl[OVC_DISCHARGE_BIT];
         supply_pullup_enable       <= otg_ctrl[OVC_PULLUP_BIT];
         indicator_pulldown_enable  <= ~otg_ctrl[OVC_EXT_SEL_BIT];
         regulator_level            <= next_reg_level;
         charger_detect_enable      <= chg_ctrl[OVC_CHG_EN_BIT];
         supply_switch_enable_n_out <= 1'b0;
         supply_switch_enable_n_oe  <= next_switch_oe;
         supply_valid_flag          <= next_supply_valid;
         session_valid_out          <= sess_s;
         line_state_out             <= next_line_state;
         uart_active                <= next_uart_active;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence drv_written;
      reg_wr && reg_addr == OVC_OTG_CTRL_ADDR && (reg_wdata[OVC_DRV_INT_BIT] || reg_wdata[OVC_DRV_EXT_BIT]);
   endsequence

   chk_switch_drive_on: assert property (drv_written |-> ##2 supply_switch_enable_n_oe)
      else $error("switch not driven after drive bit write");
   chk_switch_release: assert property (!(otg_ctrl[OVC_DRV_INT_BIT] | otg_ctrl[OVC_DRV_EXT_BIT])
      |=> !supply_switch_enable_n_oe)
      else $error("switch driven with both drive bits clear");
   chk_discharge_follow: assert property (supply_discharge_enable == $past(otg_ctrl[OVC_DISCHARGE_BIT]))
      else $error("discharge does not follow bit");
   chk_pullup_follow: assert property ($rose(otg_ctrl[OVC_PULLUP_BIT]) |=> supply_pullup_enable)
      else $error("pull-up not enabled");
   chk_internal_source: assert property (!otg_ctrl[OVC_EXT_SEL_BIT] && $stable(otg_ctrl)
      |=> supply_valid_flag == $past(comp_s))
      else $error("internal comparator not reported");
   chk_direct_source: assert property (otg_ctrl[OVC_EXT_SEL_BIT] && ifc_ctrl[OVC_DIRECT_BIT]
      |=> supply_valid_flag == ($past(ext_s) ^ $past(ifc_ctrl[OVC_INVERT_BIT])))
      else $error("direct indicator wrong");
   chk_fault_qualify: assert property (otg_ctrl[OVC_EXT_SEL_BIT] && !ifc_ctrl[OVC_DIRECT_BIT]
      && (ext_s ^ ifc_ctrl[OVC_INVERT_BIT]) |=> !supply_valid_flag)
      else $error("fault did not clear supply valid");
   chk_pin_pulldown: assert property (otg_ctrl[OVC_EXT_SEL_BIT] |=> !indicator_pulldown_enable)
      else $error("pull-down left on with external select");
   sequence uart_entry;
      $rose(uart_req);
   endsequence

   sequence uart_settled;
      uart_active && regulator_level == pwr_mgmt[OVC_UART_LVL_LSB +: 2];
   endsequence

   chk_uart_level: assert property (uart_entry |-> (##2 uart_settled) or (##2 !uart_req))
      else $error("regulator level not switched in UART");
   chk_uart_line: assert property (uart_active |-> line_state_out == 2'h0)
      else $error("line state shown in UART mode");
   chk_level_normal: assert property (!uart_active |-> regulator_level == 2'h0)
      else $error("regulator level moved outside UART");
   chk_pin_pulldown_on: assert property (!otg_ctrl[OVC_EXT_SEL_BIT] |=> indicator_pulldown_enable)
      else $error("pull-down off with external select clear");
   chk_pullup_off: assert property ($fell(otg_ctrl[OVC_PULLUP_BIT]) |=> !supply_pullup_enable)
      else $error("pull-up left on after bit cleared");
   chk_switch_low: assert property (supply_switch_enable_n_oe |-> !supply_switch_enable_n_out)
      else $error("switch pin driven high");

endmodule

/* File: verif/ovc_board_model.sv */
// Board around the block: pull-up on the switch line, indicator pin source.
// Assumes the bench steers the indicator source; the pin pull-down is the block's.
`timescale 1ns/1ps

module ovc_board_model (
   // Open-drain switch pin
   input  wire logic sw_out,
   input  wire logic sw_oe,
   output logic      sw_line,
   // Indicator pin
   input  wire logic pd_en,
   input  wire logic src_en,
   input  wire logic src_val,
   output logic      ind_pin
);
   // ****************************************
   // Wire levels
   // ****************************************
   logic last_src = 1'b0;
   // Last level driven by the source, kept while released
   always @(src_en or src_val) begin
      if (src_en) begin
         last_src <= src_val;
      end
   end
   assign sw_line = sw_oe ? sw_out : 1'b1;
   // pin pull-down, else inverse of last driven level
   assign ind_pin = src_en ? src_val : (pd_en ? 1'b0 : ~last_src);
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the supply-line control block.
// Assumes the register port answers reads one cycle later and never stalls.
`timescale 1ns/1ps

module tb;
   import ovc_pkg::*;
   typedef struct packed {
      logic [7:0] otg;
      logic [7:0] ifc;
      logic       comp;
      logic       pin;
      logic       valid;
   } ovc_row_t;
   logic       mclk = 1'b0;
   logic       rst_b = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       comp = 1'b0;
   logic       sess = 1'b0;
   logic [1:0] line = 2'h3;
   logic       src_en = 1'b1;
   logic       src_val = 1'b0;
   logic       ind_pin, dis, pu, pd, chg, sw_out, sw_oe, sw_line;
   logic       vflag, sess_o, uart;
   logic [1:0] reg_lvl, line_o;
   logic [7:0] d;
   int         miscompares = 0;
   int         checks = 0;
   ovc_row_t   rows [10] = '{
      '{8'h00, 8'h60, 1'b0, 1'b0, 1'b0}, '{8'h08, 8'h00, 1'b0, 1'b1, 1'b0},
      '{8'h10, 8'h20, 1'b1, 1'b1, 1'b1}, '{8'ha0, 8'h40, 1'b0, 1'b1, 1'b1},
      '{8'hc0, 8'h60, 1'b1, 1'b1, 1'b0}, '{8'h80, 8'h00, 1'b1, 1'b0, 1'b1},
      '{8'h80, 8'h00, 1'b1, 1'b1, 1'b0}, '{8'h80, 8'h20, 1'b1, 1'b1, 1'b1},
      '{8'he0, 8'h20, 1'b1, 1'b0, 1'b0}, '{8'h00, 8'h00, 1'b0, 1'b1, 1'b0}};

   // ****************************************
   // Design and board
   // ****************************************
   ovc_top dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comparator_supply_valid(comp),
      .session_valid_flag(sess), .line_state_raw(line), .external_indicator_pin(ind_pin),
      .supply_discharge_enable(dis), .supply_pullup_enable(pu), .indicator_pulldown_enable(pd),
      .regulator_level(reg_lvl), .charger_detect_enable(chg), .supply_switch_enable_n_out(sw_out),
      .supply_switch_enable_n_oe(sw_oe), .supply_valid_flag(vflag), .session_valid_out(sess_o),
      .line_state_out(line_o), .uart_active(uart));
   ovc_board_model board (.sw_out(sw_out), .sw_oe(sw_oe), .sw_line(sw_line), .pd_en(pd),
      .src_en(src_en), .src_val(src_val), .ind_pin(ind_pin));

   // ****************************************
   // Clock, watchdog, shared tasks
   // ****************************************
   // Free-running clock
   initial begin
      forever #2 mclk = ~mclk;
   end
   // Hang guard, well beyond the test length
   initial begin
      repeat (4000) @(posedge mclk);
      miscompares++;
      end_sim();
   end
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic settle();
      repeat (5) @(posedge mclk);
      #1;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      #1 check("sw_oe_rst", 8'(sw_oe), 8'h00);
      check("pd_rst", 8'(pd), 8'h01);
      rd(OVC_OTG_CTRL_ADDR, d);
      check("otg_rst", d, OVC_OTG_CTRL_RST);
      // Table of indicator modes and resistor controls
      // qualified rows prove the fault path only; the comparator is held high in all four of them
      foreach (rows[i]) begin
         @(posedge mclk);
         comp <= rows[i].comp;
         src_val <= rows[i].pin;
         sess <= rows[i].otg[7];
         wr(OVC_IFC_CTRL_ADDR, rows[i].ifc);
         wr(OVC_OTG_CTRL_ADDR, rows[i].otg);
         settle();
         check("valid", 8'(vflag), 8'(rows[i].valid));
         check("dis", 8'(dis), 8'(rows[i].otg[3]));
         check("pu", 8'(pu), 8'(rows[i].otg[4]));
         check("sw_line", 8'(sw_line), 8'(!(rows[i].otg[5] | rows[i].otg[6])));
         check("sw_oe", 8'(sw_oe), 8'(rows[i].otg[5] | rows[i].otg[6]));
         check("pd", 8'(pd), 8'(!rows[i].otg[7]));
         check("sess", 8'(sess_o), 8'(rows[i].otg[7]));
         rd(OVC_OTG_CTRL_ADDR, d);
         check("otg", d, rows[i].otg);
         rd(OVC_STATUS_ADDR, d);
         check("st_valid", 8'(d[OVC_ST_SUPPLY_BIT]), 8'(rows[i].valid));
      end
      // Released pin falls to the pull-down while unselected
      @(posedge mclk);
      src_en <= 1'b0;
      settle();
      check("pin_pd", 8'(ind_pin), 8'h00);
      // Unmapped place ignored, reads back zero
      wr(6'h3f, 8'hff);
      rd(6'h3f, d);
      check("unmapped", d, 8'h00);
      // Charger detection enabled then disabled by the link
      wr(OVC_CHG_CTRL_ADDR, 8'h01);
      rd(OVC_CHG_CTRL_ADDR, d);
      check("chg_rd", d, 8'h01);
      @(posedge mclk);
      #1 check("rdata_gone", reg_rdata, 8'h00);
      settle();
      check("chg_on", 8'(chg), 8'h01);
      wr(OVC_CHG_CTRL_ADDR, 8'h00);
      settle();
      check("chg_off", 8'(chg), 8'h00);
      check("line", 8'(line_o), 8'h03);
      check("lvl_sync", 8'(reg_lvl), 8'h00);
      // Entry to UART mode
      wr(OVC_PWR_MGMT_ADDR, 8'h03);
      wr(OVC_FUNC_CTRL_ADDR, 8'h10);
      settle();
      check("uart", 8'(uart), 8'h01);
      check("lvl_uart", 8'(reg_lvl), 8'h03);
      check("line_uart", 8'(line_o), 8'h00);
      // Reset in mid-run with both drive bits set
      wr(OVC_OTG_CTRL_ADDR, 8'h60);
      settle();
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1 check("sw_oe_rst2", 8'(sw_oe), 8'h00);
      check("sw_line_rst2", 8'(sw_line), 8'h01);
      rd(OVC_OTG_CTRL_ADDR, d);
      check("otg_rst2", d, 8'h00);
      end_sim();
   end
endmodule
